/* hw/wrtws_pkg.sv */
// Package with constants and types for the wiper register two-wire slave.
package wrtws_pkg;
  localparam int         DATA_W        = 8;
  localparam logic [3:0] ADDR_CODE     = 4'h5;
  localparam logic [7:0] CMD_WR_SCRATCH = 8'hA9;
  localparam logic [7:0] CMD_WR_WIPER  = 8'hAA;
  localparam logic [7:0] CMD_WR_BOTH   = 8'hAF;
  localparam logic [7:0] WIPER_RESET   = 8'h00;
  localparam logic [7:0] SCRATCH_RESET = 8'h00;
  localparam logic [3:0] BIT_LAST      = 4'h7;
  localparam logic [3:0] BIT_ACK       = 4'h8;
  localparam int         CLK_HZ        = 50000000;
  localparam int         SCL_FAST_HZ   = 400000;
  localparam int         SCL_FAST_CYC  = CLK_HZ / SCL_FAST_HZ;

  typedef struct packed {
    logic scl;
    logic sda;
  } wrtws_bus_t;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_ADDR = 5'b00010,
    ST_CMD  = 5'b00100,
    ST_WDAT = 5'b01000,
    ST_RDAT = 5'b10000
  } wrtws_state_t;
endpackage : wrtws_pkg

/* hw/wrtws_slave.sv */
// Two-wire slave holding the scratch byte and the wiper position register.
// Overview of operation
// (RULE1) Two 8-bit registers: scratch byte and wiper position.
// (RULE2) Wiper register drives a one-of-256 tap select; 00h is low terminal.
// (RULE3) Wiper register loads 00h at power-up reset.
// (RULE4) Three address select pins form the device address.
// (RULE5) Slave only; SCL is input, never generates clocks or conditions.
// (RULE6) Master makes every clock pulse and every START and STOP.
// (RULE7) Master starts only when SDA and SCL are both high.
// (RULE8) SDA changes only while SCL low; changes in SCL high are conditions.
// (RULE9) SDA fall with SCL high is START; SDA rise is STOP.
// (RULE10) One SCL pulse per bit, sampled during the high period.
// (RULE11) Bytes of eight bits plus a ninth acknowledge bit by receiver.
// (RULE12) Any number of bytes between START and STOP is accepted.
// (RULE13) Works with bus clocks up to 100kHz and 400kHz.
// (RULE14) Master supplies a ninth clock pulse after every byte.
// (RULE15) Acknowledger holds SDA low before and through the ninth clock high.
// (RULE16) On master not-acknowledge the device releases SDA and stops sending.
// (RULE17) Written address byte and all following bytes are acknowledged.
// (RULE18) Master acknowledges read bytes except the last one.
// (RULE19) SDA is open drain: pulled low or released, never driven high.
// (RULE20) Address matches 0101 plus select pins; last bit is read or write.
// (RULE21) Command A9h writes scratch, AAh writes wiper, AFh writes both.
// (RULE22) Reads return the scratch byte first, then the wiper register.
// (RULE23) All bytes travel most significant bit first.
// (RULE24) SCL and SDA are synchronised and edges detected internally.
module wrtws_slave
(
  input  wire logic                     sys_clk,
  input  wire logic                     sys_rst,
  input  wire wrtws_pkg::wrtws_bus_t    bus_in,
  input  wire logic [2:0]               addr_select,
  output logic                          sda_out,
  output logic                          sda_oe_n,
  output logic [255:0]                  tap_select,
  output logic [7:0]                    scratch_byte,
  output logic [7:0]                    wiper_position
);
  import wrtws_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers and edge detection.
  wrtws_bus_t   sync1_reg;
  wrtws_bus_t   sync2_reg;
  wrtws_bus_t   prev_reg;
  logic [2:0]   asel1_reg;
  logic [2:0]   asel2_reg;

  // (RULE24) two-stage synchroniser
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sync1_reg <= '{scl: 1'b1, sda: 1'b1};
      sync2_reg <= '{scl: 1'b1, sda: 1'b1};
      prev_reg  <= '{scl: 1'b1, sda: 1'b1};
      asel1_reg <= 3'h0;
      asel2_reg <= 3'h0;
    end
    else
    begin
      sync1_reg <= bus_in;
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
      // (RULE4) select pins sampled
      asel1_reg <= addr_select;
      asel2_reg <= asel1_reg;
    end
  end

  // (RULE5) clock pin input only
  wire scl_rise;
  wire scl_fall;
  wire start_det;
  wire stop_det;
  // (RULE9) start and stop decode
  assign start_det = sync2_reg.scl && prev_reg.scl && prev_reg.sda && !sync2_reg.sda;
  assign stop_det  = sync2_reg.scl && prev_reg.scl && !prev_reg.sda && sync2_reg.sda;
  // (RULE10) sample on clock rise
  assign scl_rise  = sync2_reg.scl && !prev_reg.scl;
  assign scl_fall  = !sync2_reg.scl && prev_reg.scl;

  ////////////////////////////////////////////////////////////////////////////
  // Byte engine state.
  wrtws_state_t state_reg;
  wrtws_state_t state_next;
  logic [3:0]   bit_reg;
  logic         armed_reg;
  logic [7:0]   shift_reg;
  logic [7:0]   cmd_reg;
  logic         rd_sel_reg;
  logic         ack_ok_reg;
  logic         nack_reg;
  logic         drive_low_reg;
  logic [7:0]   scratch_reg;
  logic [7:0]   wiper_reg;

  wire          byte_done;
  wire          ack_slot_end;
  wire          addr_match;
  wire [7:0]    rx_byte;
  wire [7:0]    tx_byte;
  wire          tx_bit;

  assign rx_byte      = {shift_reg[6:0], sync2_reg.sda};
  // (RULE11) eighth bit then ack slot
  assign byte_done    = scl_rise && (bit_reg == BIT_LAST);
  assign ack_slot_end = scl_fall && (bit_reg == BIT_ACK);
  // (RULE20) address decode
  assign addr_match   = (rx_byte[7:4] == ADDR_CODE) && (rx_byte[3:1] == asel2_reg);
  // (RULE22) scratch then wiper
  assign tx_byte      = rd_sel_reg ? wiper_reg : scratch_reg;
  // (RULE23) most significant first
  assign tx_bit       = tx_byte[3'(BIT_LAST - bit_reg)];

  always_comb
  begin
    state_next = state_reg;
    if (ack_slot_end)
    begin
      unique case (state_reg)
        ST_ADDR: state_next = !ack_ok_reg ? ST_IDLE : (shift_reg[0] ? ST_RDAT : ST_CMD);
        ST_CMD:  state_next = ST_WDAT;
        // (RULE12) no byte limit
        ST_WDAT: state_next = ST_WDAT;
        // (RULE16) stop on not-acknowledge
        ST_RDAT: state_next = nack_reg ? ST_IDLE : ST_RDAT;
        ST_IDLE: state_next = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      state_reg <= ST_IDLE;
    else if (start_det)
      state_reg <= ST_ADDR;
    else if (stop_det)
      state_reg <= ST_IDLE;
    else
      state_reg <= state_next;
  end

  // (RULE13) one count per pulse
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      bit_reg <= 4'h0;
    else if (start_det || ack_slot_end)
      bit_reg <= 4'h0;
    else if (scl_fall && armed_reg && bit_reg != BIT_ACK)
      bit_reg <= bit_reg + 4'h1;
  end

  // The clock fall that closes a START carries no bit and is not counted.
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      armed_reg <= 1'b0;
    else if (start_det)
      armed_reg <= 1'b0;
    else if (scl_rise)
      armed_reg <= 1'b1;
  end

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      shift_reg  <= 8'h00;
      cmd_reg    <= 8'h00;
      ack_ok_reg <= 1'b0;
      nack_reg   <= 1'b0;
      rd_sel_reg <= 1'b0;
    end
    else
    begin
      if (start_det)
        rd_sel_reg <= 1'b0;
      if (scl_rise && bit_reg <= BIT_LAST)
        shift_reg <= rx_byte;
      if (byte_done && state_reg == ST_ADDR)
        ack_ok_reg <= addr_match;
      if (byte_done && state_reg == ST_CMD)
        cmd_reg <= rx_byte;
      if (scl_rise && bit_reg == BIT_ACK)
        nack_reg <= sync2_reg.sda;
      if (ack_slot_end && state_reg == ST_RDAT)
        rd_sel_reg <= ~rd_sel_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register file.
  // (RULE1) two 8-bit registers
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      // (RULE3) wiper cleared at power-up
      wiper_reg   <= WIPER_RESET;
      scratch_reg <= SCRATCH_RESET;
    end
    else if (byte_done && state_reg == ST_WDAT)
    begin
      // (RULE21) command decode
      if (cmd_reg == CMD_WR_SCRATCH || cmd_reg == CMD_WR_BOTH)
        scratch_reg <= rx_byte;
      if (cmd_reg == CMD_WR_WIPER || cmd_reg == CMD_WR_BOTH)
        wiper_reg <= rx_byte;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // SDA open-drain driver.
  wire drive_low_next;
  // (RULE17) acknowledge received bytes
  assign drive_low_next =
      (bit_reg == BIT_ACK && state_reg == ST_ADDR && ack_ok_reg)
    || (bit_reg == BIT_ACK && (state_reg == ST_CMD || state_reg == ST_WDAT))
    || (bit_reg <= BIT_LAST && state_reg == ST_RDAT && !tx_bit);

  // (RULE15) hold low through ack clock
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      drive_low_reg <= 1'b0;
    else if (start_det || stop_det)
      drive_low_reg <= 1'b0;
    // (RULE8) change while low
    else if (!sync2_reg.scl)
      drive_low_reg <= drive_low_next;
  end

  // (RULE19) never drive high
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sda_out  <= 1'b0;
      sda_oe_n <= 1'b1;
    end
    else
    begin
      sda_out  <= 1'b0;
      sda_oe_n <= ~drive_low_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Tap select and register outputs.
  // (RULE2) one-hot tap
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      tap_select     <= 256'h1;
      scratch_byte   <= SCRATCH_RESET;
      wiper_position <= WIPER_RESET;
    end
    else
    begin
      tap_select     <= 256'h1 << wiper_reg;
      scratch_byte   <= scratch_reg;
      wiper_position <= wiper_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.
  property p_open_drain;
    @(posedge sys_clk) disable iff (sys_rst) sda_out == 1'b0;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("SDA driven high."); // (RULE19)

  property p_wiper_tap;
    @(posedge sys_clk) disable iff (sys_rst) ##1 tap_select == (256'h1 << $past(wiper_reg));
  endproperty
  a_wiper_tap: assert property (p_wiper_tap) else $error("Tap select mismatch."); // (RULE2)

  property p_start_addr;
    @(posedge sys_clk) disable iff (sys_rst) start_det |=> state_reg == ST_ADDR;
  endproperty
  a_start_addr: assert property (p_start_addr) else $error("Start not seen."); // (RULE9)

  property p_stop_idle;
    @(posedge sys_clk) disable iff (sys_rst) stop_det && !start_det |=> state_reg == ST_IDLE;
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("Stop not seen."); // (RULE9)

  property p_bad_addr;
    @(posedge sys_clk) disable iff (sys_rst)
      byte_done && state_reg == ST_ADDR && !addr_match |=> !ack_ok_reg;
  endproperty
  a_bad_addr: assert property (p_bad_addr) else $error("Foreign address taken."); // (RULE20)

  property p_write_wiper;
    @(posedge sys_clk) disable iff (sys_rst)
      byte_done && state_reg == ST_WDAT && cmd_reg == CMD_WR_BOTH |=> wiper_reg == scratch_reg;
  endproperty
  a_write_wiper: assert property (p_write_wiper) else $error("Write both failed."); // (RULE21)

  property p_nack_release;
    @(posedge sys_clk) disable iff (sys_rst)
      ack_slot_end && state_reg == ST_RDAT && nack_reg |=> ##[1:3] sda_oe_n && state_reg == ST_IDLE;
  endproperty
  a_nack_release: assert property (p_nack_release) else $error("SDA held after nack."); // (RULE16)

  property p_ack_stable;
    @(posedge sys_clk) disable iff (sys_rst)
      scl_rise && bit_reg == BIT_ACK && state_reg == ST_CMD |-> !sda_oe_n;
  endproperty
  a_ack_stable: assert property (p_ack_stable) else $error("Ack missing."); // (RULE15)
endmodule : wrtws_slave

/* verif/wrtws_master_model.sv */
// Bus master model that clocks the two-wire slave.
module wrtws_master_model
#(
  parameter int T_LOW  = 120,
  parameter int T_HIGH = 40
)
(
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda_rel
);
  timeunit 1ns;
  timeprecision 1ps;
  //////////////////////////////////////////////////////////////////////////////
  // idle bus
  initial
  begin
    scl     = 1'b1;
    sda_rel = 1'b1;
  end
  task automatic start();
    begin
      #(T_LOW / 2) sda_rel = 1'b1;
      #(T_LOW / 2) scl = 1'b1;
      #T_HIGH sda_rel = 1'b0;
      #T_HIGH scl = 1'b0;
    end
  endtask : start
  task automatic stop();
    begin
      #(T_LOW / 2) sda_rel = 1'b0;
      #(T_LOW / 2) scl = 1'b1;
      #T_HIGH sda_rel = 1'b1;
      #(4 * T_HIGH);
    end
  endtask : stop
  task automatic clk_bit(input logic b, output logic s);
    begin
      #(T_LOW / 2) sda_rel = b;
      #(T_LOW / 2) scl = 1'b1;
      #(T_HIGH / 2) s = sda_line;
      #(T_HIGH / 2) scl = 1'b0;
    end
  endtask : clk_bit
  task automatic write_byte(input logic [7:0] b, output logic ack);
    logic s;
    begin
      for (int i = 7; i >= 0; i--)
        clk_bit(b[i], s);
      clk_bit(1'b1, s);
      ack = ~s;
    end
  endtask : write_byte
  task automatic read_byte(input logic nack, output logic [7:0] d);
    logic s;
    begin
      for (int i = 7; i >= 0; i--)
        clk_bit(1'b1, d[i]);
      clk_bit(nack, s);
    end
  endtask : read_byte
endmodule : wrtws_master_model

/* verif/tb_top.sv */
// Self-checking testbench for the wiper register two-wire slave.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import wrtws_pkg::*;
  localparam logic [2:0] SEL = 3'h5;
  localparam logic [7:0] AW  = {ADDR_CODE, SEL, 1'b0};
  localparam logic [7:0] AR  = {ADDR_CODE, SEL, 1'b1};
  logic         sys_clk;
  logic         sys_rst;
  logic [2:0]   addr_select;
  logic         scl;
  logic         sda_rel;
  logic         sda_line;
  logic         sda_out;
  logic         sda_oe_n;
  logic [255:0] tap_select;
  logic [7:0]   scratch_byte;
  logic [7:0]   wiper_position;
  wrtws_bus_t   bus;
  int           bad_count;
  int           checks_done;
  int           cycles = 0;
  //////////////////////////////////////////////////////////////////////////////
  assign sda_line = sda_rel & (sda_oe_n | sda_out);
  assign bus.scl  = scl;
  assign bus.sda  = sda_line;
  wrtws_slave uut (.sys_clk(sys_clk), .sys_rst(sys_rst), .bus_in(bus),
    .addr_select(addr_select), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .tap_select(tap_select), .scratch_byte(scratch_byte),
    .wiper_position(wiper_position));
  wrtws_master_model u_mst (.sda_line(sda_line), .scl(scl), .sda_rel(sda_rel));
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  task automatic report_and_stop();
    begin
      $display("Checks %0d, errors %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask : report_and_stop
  always @(posedge sys_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 40000)
    begin
      bad_count = bad_count + 1;
      report_and_stop();
    end
  end
  task automatic chk(input logic [255:0] seen, input logic [255:0] exp);
    begin
      checks_done = checks_done + 1;
      if (seen !== exp)
      begin
        bad_count = bad_count + 1;
        $display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
      end
    end
  endtask : chk
  task automatic wbyte(input logic [7:0] b, input logic exp_ack);
    logic a;
    begin
      u_mst.write_byte(b, a);
      chk(256'(a), 256'(exp_ack));
    end
  endtask : wbyte
  task automatic rbyte(input logic nack, input logic [7:0] exp);
    logic [7:0] d;
    begin
      u_mst.read_byte(nack, d);
      chk(256'(d), 256'(exp));
    end
  endtask : rbyte
  task automatic wr(input logic [7:0] cmd, input logic [7:0] d);
    begin
      u_mst.start();
      wbyte(AW, 1'b1);
      wbyte(cmd, 1'b1);
      wbyte(d, 1'b1);
    end
  endtask : wr
  task automatic regs(input logic [7:0] s, input logic [7:0] w);
    begin
      chk(256'(scratch_byte), 256'(s));
      chk(256'(wiper_position), 256'(w));
      chk(tap_select, 256'h1 << w);
    end
  endtask : regs
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    bad_count = 0;
    checks_done = 0;
    sys_rst = 1'b1;
    addr_select = SEL;
    repeat (8) @(posedge sys_clk);
    @(negedge sys_clk) sys_rst = 1'b0;
    repeat (8) @(negedge sys_clk);
    regs(SCRATCH_RESET, WIPER_RESET);
    wr(CMD_WR_WIPER, 8'h3C);
    u_mst.stop();
    regs(8'h00, 8'h3C);
    wr(CMD_WR_SCRATCH, 8'h11);
    wbyte(8'h22, 1'b1);
    u_mst.stop();
    regs(8'h22, 8'h3C);
    wr(CMD_WR_BOTH, 8'hFF);
    u_mst.stop();
    regs(8'hFF, 8'hFF);
    wr(8'h00, 8'h44);
    u_mst.stop();
    regs(8'hFF, 8'hFF);
    for (int i = 0; i < 4; i++)
    begin
      u_mst.start();
      wbyte(AW ^ (8'h02 << i), 1'b0);
      wbyte(CMD_WR_WIPER, 1'b0);
      u_mst.stop();
    end
    wr(CMD_WR_WIPER, 8'hA5);
    wr(CMD_WR_SCRATCH, 8'h5A);
    u_mst.stop();
    regs(8'h5A, 8'hA5);
    u_mst.start();
    wbyte(AR, 1'b1);
    rbyte(1'b0, 8'h5A);
    rbyte(1'b0, 8'hA5);
    rbyte(1'b1, 8'h5A);
    #100 chk(256'(sda_oe_n), 256'(1'b1));
    chk(256'(sda_out), 256'(1'b0));
    u_mst.stop();
    regs(8'h5A, 8'hA5);
    report_and_stop();
  end
endmodule : tb_top
